// ==== hdl/telemetry_pkg.sv ====
// Shared constants and types of the power telemetry block.
package telemetry_pkg;

    // -----------------------------------------------------------------
    // Clock and timing
    // -----------------------------------------------------------------
    localparam int CLK_HZ          = 25_000_000;
    localparam int CLK_PER_US      = CLK_HZ / 1_000_000;
    // One averaging tick; 256 ticks make the 4 s averaging window.
    localparam int AVG_TICK_US     = 15_625;
    localparam int AVG_TICK_CYC    = AVG_TICK_US * CLK_PER_US;
    localparam int AVG_LOG2        = 8;
    // Longest allowed gap between accumulator updates (must stay below 100 ms).
    localparam int UPDATE_LIMIT_MS = 100;
    localparam int UPDATE_MAX_MS   = 90;
    localparam int UPDATE_MAX_CYC  = UPDATE_MAX_MS * 1000 * CLK_PER_US;
    // Output energy sample period.
    localparam int EOUT_SAMPLE_MS  = 50;
    localparam int EOUT_SAMPLE_CYC = EOUT_SAMPLE_MS * 1000 * CLK_PER_US;
    localparam logic [1:0] AC_CYCLES_LAST = 2'h3;

    // -----------------------------------------------------------------
    // Command codes
    // -----------------------------------------------------------------
    localparam logic [7:0] CMD_READ_EIN  = 8'h86;
    localparam logic [7:0] CMD_READ_EOUT = 8'h87;
    localparam logic [7:0] CMD_READ_IOUT = 8'h8C;
    localparam logic [7:0] CMD_READ_PIN  = 8'h97;

    // -----------------------------------------------------------------
    // Direct-format coefficients of the energy readings
    // -----------------------------------------------------------------
    localparam logic [15:0] COEF_M = 16'h0001;
    localparam logic [15:0] COEF_B = 16'h0000;
    localparam logic [7:0]  COEF_R = 8'h00;

    // -----------------------------------------------------------------
    // Accumulator layout and reset values
    // -----------------------------------------------------------------
    localparam int          ACC_W      = 15;
    localparam logic [14:0] ACC_MAX    = 15'h7FFF;
    localparam logic [14:0] ACC_RST    = 15'h0000;
    localparam logic [7:0]  ROLL_RST   = 8'h00;
    localparam logic [23:0] COUNT_RST  = 24'h000000;
    localparam logic [7:0]  BLOCK_LEN  = 8'h06;
    localparam logic [3:0]  FRAME_BLK  = 4'h7;
    localparam logic [3:0]  FRAME_WORD = 4'h2;
    localparam logic [7:0]  CRC_POLY   = 8'h07;

    typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_SEND} rsp_state_t;

endpackage

// ==== hdl/accum_if.sv ====
// Carrier between the command logic and one energy accumulator.
`timescale 1ns/10ps
interface accum_if;
    logic        add;
    logic [14:0] psample;
    logic        clear;
    logic        snap;
    logic [14:0] snap_accum;
    logic [7:0]  snap_roll;
    logic [23:0] snap_count;

    modport ctrl (output add, psample, clear, snap, input snap_accum, snap_roll, snap_count);
    modport acc  (input add, psample, clear, snap, output snap_accum, snap_roll, snap_count);
endinterface

// ==== hdl/energy_accum.sv ====
// Energy accumulator with rollover counter, sample count and atomic readout.
`timescale 1ns/10ps
module energy_accum
    import telemetry_pkg::*;
(
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // Control and readout
    accum_if.acc      bus
);
    import telemetry_pkg::*;

    logic [14:0] accum;
    logic [7:0]  roll;
    logic [23:0] count;
    logic [15:0] sum;

    assign sum = {1'b0, accum} + {1'b0, bus.psample};

    // -----------------------------------------------------------------
    // Accumulation
    // -----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst || bus.clear) begin
            accum <= ACC_RST;
            roll  <= ROLL_RST;
            count <= COUNT_RST;
        end else if (bus.add) begin
            accum <= sum[14:0];
            if (sum > {1'b0, ACC_MAX}) begin
                roll <= roll + 8'h01;
            end
            count <= count + 24'h000001;
        end
    end

    // -----------------------------------------------------------------
    // Readout
    // -----------------------------------------------------------------
    // A snapshot in an add cycle holds the pre-add values, so sum and count agree.
    always_ff @(posedge mclk) begin
        if (rst || bus.clear) begin
            bus.snap_accum <= ACC_RST;
            bus.snap_roll  <= ROLL_RST;
            bus.snap_count <= COUNT_RST;
        end else if (bus.snap) begin
            bus.snap_accum <= accum;
            bus.snap_roll  <= roll;
            bus.snap_count <= count;
        end
    end

endmodule

// ==== hdl/pmbus_power_telemetry.sv ====
// Power telemetry: averaged input power and output current, energy counters, readout.
//
// Contract
// - Answer 97h with linear-format input power.
// - Input power is simple average, fixed.
// - Averaging window between 2 and 10 s.
// - Filter bandwidth 0.1 to 0.5 Hz.
// - Input power reads 0 W without AC.
// - Answer 8Ch with linear-format output current.
// - Output current averaged over 2-10 s window.
// - 86h/87h return power sum and count.
// - Input sample averages four AC cycles.
// - Accumulator update period below 100 ms.
// - Direct format, m=1, R=0, b=0.
// - Coefficients constant and readable.
// - Energy reads are block read with PEC.
// - Accumulator 15 bits, wraps past 7FFFh.
// - Rollover byte wraps FFh to 00h.
// - Three-byte sample count, one per sample.
// - Sum, rollover, count captured together.
`timescale 1ns/10ps
module pmbus_power_telemetry
    import telemetry_pkg::*;
#(
    parameter int AVG_TICK_CYCLES  = telemetry_pkg::AVG_TICK_CYC,
    parameter int UPDATE_MAX_CYCLES = telemetry_pkg::UPDATE_MAX_CYC,
    parameter int EOUT_CYCLES      = telemetry_pkg::EOUT_SAMPLE_CYC
)(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // Measurements
    input  wire logic        ac_present,
    input  wire logic        ac_shutdown,
    input  wire logic        ac_cycle,
    input  wire logic [15:0] pin_cycle,
    input  wire logic [15:0] pin_meas,
    input  wire logic [15:0] iout_meas,
    input  wire logic [14:0] pout_meas,
    // Command side
    input  wire logic [6:0]  dev_addr,
    input  wire logic        pec_en,
    input  wire logic        cmd_valid,
    input  wire logic [7:0]  cmd_code,
    output logic             cmd_ready,
    output logic             cmd_reject,
    // Answer byte stream
    output logic             rsp_valid,
    output logic [7:0]       rsp_data,
    output logic             rsp_last,
    input  wire logic        rsp_ready,
    // Coefficients of the energy readings
    output logic [15:0]      coef_m,
    output logic [15:0]      coef_b,
    output logic [7:0]       coef_r
);
    import telemetry_pkg::*;

    // -----------------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------------
    function automatic logic [15:0] to_linear(input logic [15:0] v);
        logic [15:0] m;
        logic [4:0]  e;
        m = v;
        e = 5'h00;
        for (int i = 0; i < 6; i++) begin
            if (m > 16'h03FF) begin
                m = m >> 1;
                e = e + 5'h01;
            end
        end
        return {e, m[10:0]};
    endfunction

    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    accum_if ein_bus ();
    accum_if eout_bus ();

    energy_accum u_ein (.mclk(mclk), .rst(rst), .bus(ein_bus));
    energy_accum u_eout (.mclk(mclk), .rst(rst), .bus(eout_bus));

    assign coef_m = COEF_M;
    assign coef_b = COEF_B;
    assign coef_r = COEF_R;

    // -----------------------------------------------------------------
    // Averaging of input power and output current
    // -----------------------------------------------------------------
    // A 4 s boxcar of 256 ticks; a power-of-two count avoids any divider.
    logic [31:0] tick_cnt;
    logic        avg_tick;
    logic [7:0]  avg_idx;
    logic [23:0] pin_sum;
    logic [23:0] iout_sum;
    logic [15:0] pin_avg;
    logic [15:0] iout_avg;

    assign avg_tick = (tick_cnt == 32'(AVG_TICK_CYCLES - 1));

    always_ff @(posedge mclk) begin
        if (rst || avg_tick) begin
            tick_cnt <= 32'h00000000;
        end else begin
            tick_cnt <= tick_cnt + 32'h00000001;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            avg_idx  <= 8'h00;
            pin_sum  <= 24'h000000;
            iout_sum <= 24'h000000;
            pin_avg  <= 16'h0000;
            iout_avg <= 16'h0000;
        end else if (!ac_present) begin
            pin_sum <= 24'h000000;
            pin_avg <= 16'h0000;
            if (avg_tick) begin
                avg_idx  <= avg_idx + 8'h01;
                iout_sum <= (avg_idx == 8'hFF) ? 24'h000000 : iout_sum + {8'h00, iout_meas};
                if (avg_idx == 8'hFF) begin
                    iout_avg <= 16'((iout_sum + {8'h00, iout_meas}) >> AVG_LOG2);
                end
            end
        end else if (avg_tick) begin
            avg_idx <= avg_idx + 8'h01;
            if (avg_idx == 8'hFF) begin
                pin_avg  <= 16'((pin_sum + {8'h00, pin_meas}) >> AVG_LOG2);
                iout_avg <= 16'((iout_sum + {8'h00, iout_meas}) >> AVG_LOG2);
                pin_sum  <= 24'h000000;
                iout_sum <= 24'h000000;
            end else begin
                pin_sum  <= pin_sum + {8'h00, pin_meas};
                iout_sum <= iout_sum + {8'h00, iout_meas};
            end
        end
    end

    // -----------------------------------------------------------------
    // Input energy samples
    // -----------------------------------------------------------------
    logic [17:0] cyc_sum;
    logic [1:0]  cyc_idx;
    logic [31:0] upd_cnt;
    logic [17:0] cyc_total;
    logic        cyc_done;
    logic        upd_timeout;
    logic [15:0] cyc_avg;

    assign cyc_total   = cyc_sum + {2'h0, pin_cycle};
    assign cyc_done    = ac_present && ac_cycle && (cyc_idx == AC_CYCLES_LAST);
    assign upd_timeout = (upd_cnt == 32'(UPDATE_MAX_CYCLES - 1));
    assign cyc_avg     = cyc_total[17:2];

    always_ff @(posedge mclk) begin
        if (rst || cyc_done || upd_timeout) begin
            cyc_sum <= 18'h00000;
            cyc_idx <= 2'h0;
        end else if (ac_present && ac_cycle) begin
            cyc_sum <= cyc_total;
            cyc_idx <= cyc_idx + 2'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst || cyc_done || upd_timeout) begin
            upd_cnt <= 32'h00000000;
        end else begin
            upd_cnt <= upd_cnt + 32'h00000001;
        end
    end

    assign ein_bus.add     = cyc_done || upd_timeout;
    assign ein_bus.psample = !cyc_done ? ACC_RST :
                             (cyc_avg > {1'b0, ACC_MAX}) ? ACC_MAX : cyc_avg[14:0];
    assign ein_bus.clear   = ac_shutdown;

    // -----------------------------------------------------------------
    // Output energy samples
    // -----------------------------------------------------------------
    logic [31:0] eout_cnt;
    logic        eout_tick;

    assign eout_tick = (eout_cnt == 32'(EOUT_CYCLES - 1));

    always_ff @(posedge mclk) begin
        if (rst || eout_tick) begin
            eout_cnt <= 32'h00000000;
        end else begin
            eout_cnt <= eout_cnt + 32'h00000001;
        end
    end

    assign eout_bus.add     = eout_tick;
    assign eout_bus.psample = pout_meas;
    assign eout_bus.clear   = ac_shutdown;

    // -----------------------------------------------------------------
    // Command answer
    // -----------------------------------------------------------------
    rsp_state_t  state;
    logic [7:0]  code;
    logic [7:0]  frame [0:6];
    logic [3:0]  len;
    logic [3:0]  idx;
    logic [7:0]  crc;
    logic        send_pec;
    logic        known;
    logic        is_energy;
    logic        take;
    logic        beat;
    logic [15:0] word_lin;

    assign known     = (cmd_code == CMD_READ_EIN) || (cmd_code == CMD_READ_EOUT) ||
                       (cmd_code == CMD_READ_IOUT) || (cmd_code == CMD_READ_PIN);
    assign is_energy = (code == CMD_READ_EIN) || (code == CMD_READ_EOUT);
    assign cmd_ready = (state == ST_IDLE);
    assign take      = cmd_valid && cmd_ready;
    assign beat      = rsp_valid && rsp_ready;
    assign rsp_valid = (state == ST_SEND);
    assign rsp_last  = rsp_valid && (send_pec ? (idx == len) : (idx == len - 4'h1));
    assign ein_bus.snap  = take && (cmd_code == CMD_READ_EIN);
    assign eout_bus.snap = take && (cmd_code == CMD_READ_EOUT);
    assign word_lin  = to_linear((code == CMD_READ_PIN) ? pin_avg : iout_avg);

    always_ff @(posedge mclk) begin
        if (rst) begin
            cmd_reject <= 1'b0;
        end else begin
            cmd_reject <= cmd_valid && cmd_ready && !known;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state    <= ST_IDLE;
            code     <= 8'h00;
            len      <= 4'h0;
            idx      <= 4'h0;
            crc      <= 8'h00;
            send_pec <= 1'b0;
            rsp_data <= 8'h00;
            for (int i = 0; i < 7; i++) begin
                frame[i] <= 8'h00;
            end
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (take && known) begin
                        state <= ST_LOAD;
                        code  <= cmd_code;
                        crc   <= crc8(crc8(crc8(8'h00, {dev_addr, 1'b0}), cmd_code),
                                      {dev_addr, 1'b1});
                    end
                end
                ST_LOAD: begin
                    state <= ST_SEND;
                    idx   <= 4'h0;
                    if (is_energy) begin
                        // Block of six bytes, PEC always.
                        len      <= FRAME_BLK;
                        send_pec <= 1'b1;
                        rsp_data <= BLOCK_LEN;
                        frame[0] <= BLOCK_LEN;
                        if (code == CMD_READ_EIN) begin
                            frame[1] <= ein_bus.snap_accum[7:0];
                            frame[2] <= {1'b0, ein_bus.snap_accum[14:8]};
                            frame[3] <= ein_bus.snap_roll;
                            frame[4] <= ein_bus.snap_count[7:0];
                            frame[5] <= ein_bus.snap_count[15:8];
                            frame[6] <= ein_bus.snap_count[23:16];
                        end else begin
                            frame[1] <= eout_bus.snap_accum[7:0];
                            frame[2] <= {1'b0, eout_bus.snap_accum[14:8]};
                            frame[3] <= eout_bus.snap_roll;
                            frame[4] <= eout_bus.snap_count[7:0];
                            frame[5] <= eout_bus.snap_count[15:8];
                            frame[6] <= eout_bus.snap_count[23:16];
                        end
                    end else begin
                        len      <= FRAME_WORD;
                        send_pec <= pec_en;
                        frame[0] <= word_lin[7:0];
                        frame[1] <= word_lin[15:8];
                        rsp_data <= word_lin[7:0];
                    end
                end
                ST_SEND: begin
                    if (beat) begin
                        if (rsp_last) begin
                            state <= ST_IDLE;
                        end else begin
                            idx <= idx + 4'h1;
                            crc <= crc8(crc, rsp_data);
                            rsp_data <= (idx + 4'h1 == len) ? crc8(crc, rsp_data) :
                                        frame[3'(idx + 4'h1)];
                        end
                    end
                end
            endcase
        end
    end

endmodule

// ==== test/telemetry_chk.sv ====
// Port assertions of the power telemetry block.
`timescale 1ns/10ps
module telemetry_chk (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        rst,
    // Command side
    input wire logic        pec_en,
    input wire logic        cmd_valid,
    input wire logic [7:0]  cmd_code,
    input wire logic        cmd_ready,
    input wire logic        cmd_reject,
    // Answer stream
    input wire logic        rsp_valid,
    input wire logic [7:0]  rsp_data,
    input wire logic        rsp_last,
    input wire logic        rsp_ready,
    // Coefficients
    input wire logic [15:0] coef_m,
    input wire logic [15:0] coef_b,
    input wire logic [7:0]  coef_r
);
    import telemetry_pkg::*;

    logic [7:0] code;
    logic [3:0] beats;
    logic       energy;
    logic       known;

    assign energy = (code == CMD_READ_EIN) || (code == CMD_READ_EOUT);
    assign known  = (cmd_code == CMD_READ_EIN) || (cmd_code == CMD_READ_EOUT) ||
                    (cmd_code == CMD_READ_PIN) || (cmd_code == CMD_READ_IOUT);

    always_ff @(posedge mclk) begin
        if (rst) begin
            code <= 8'h00;
        end else if (cmd_valid && cmd_ready) begin
            code <= cmd_code;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst || (cmd_valid && cmd_ready)) begin
            beats <= 4'h0;
        end else if (rsp_valid && rsp_ready) begin
            beats <= beats + 4'h1;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_take_known;
        cmd_valid && cmd_ready && known;
    endsequence
    sequence s_load_send;
        (!cmd_ready && !rsp_valid) ##1 rsp_valid;
    endsequence

    property p_answer;
        s_take_known |=> s_load_send;
    endproperty
    property p_first;
        $rose(rsp_valid) && energy |-> rsp_data == 8'h06;
    endproperty
    property p_energy_len;
        rsp_valid && rsp_last && energy |-> beats == 4'h7;
    endproperty
    property p_word_len;
        rsp_valid && rsp_last && !energy |-> beats == (pec_en ? 4'h2 : 4'h1);
    endproperty
    property p_stand;
        rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data) && $stable(rsp_last);
    endproperty
    property p_refuse;
        rsp_valid |-> !cmd_ready;
    endproperty
    property p_free;
        rsp_valid && rsp_ready && rsp_last |=> cmd_ready && !rsp_valid;
    endproperty
    property p_reject;
        cmd_valid && cmd_ready && !known |=>
            (cmd_reject && !rsp_valid) ##1 (!cmd_reject && !rsp_valid);
    endproperty
    property p_coef;
        coef_m == 16'h0001 && coef_b == 16'h0000 && coef_r == 8'h00;
    endproperty

    a_answer: assert property (p_answer)
        else $error("late answer");
    a_first: assert property (p_first)
        else $error("energy count byte wrong");
    a_energy_len: assert property (p_energy_len)
        else $error("energy length wrong");
    a_word_len: assert property (p_word_len)
        else $error("word length wrong");
    a_stand: assert property (p_stand)
        else $error("byte moved in stall");
    a_refuse: assert property (p_refuse)
        else $error("ready during answer");
    a_free: assert property (p_free)
        else $error("not idle after last");
    a_reject: assert property (p_reject)
        else $error("bad reject pulse");
    a_coef: assert property (p_coef)
        else $error("coefficients wrong");
endmodule

bind pmbus_power_telemetry telemetry_chk chk (
    .mclk(mclk), .rst(rst), .pec_en(pec_en), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_ready(cmd_ready), .cmd_reject(cmd_reject), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_last(rsp_last), .rsp_ready(rsp_ready), .coef_m(coef_m),
    .coef_b(coef_b), .coef_r(coef_r));

// ==== test/host_model.sv ====
// Polling host that issues one command and collects its answer bytes.
`timescale 1ns/10ps
module host_model (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // Bench control
    input  wire logic        go,
    input  wire logic [7:0]  code,
    input  wire logic        slow,
    output logic [0:7][7:0]  got,
    output logic [3:0]       count,
    output logic             done,
    // Command and answer side
    output logic             cmd_valid,
    output logic [7:0]       cmd_code,
    input  wire logic        cmd_ready,
    input  wire logic        cmd_reject,
    input  wire logic        rsp_valid,
    input  wire logic [7:0]  rsp_data,
    input  wire logic        rsp_last,
    output logic             rsp_ready
);
    always_ff @(posedge mclk) begin
        if (rst) begin
            cmd_valid <= 1'b0;
            cmd_code  <= 8'h00;
        end else if (go) begin
            cmd_valid <= 1'b1;
            cmd_code  <= code;
        end else if (cmd_valid && cmd_ready) begin
            cmd_valid <= 1'b0;
            cmd_code  <= ~cmd_code;
        end
    end

    // Slow mode drops ready every other cycle.
    always_ff @(posedge mclk) begin
        if (rst) begin
            rsp_ready <= 1'b0;
        end else begin
            rsp_ready <= slow ? ~rsp_ready : 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst || go) begin
            count <= 4'h0;
            done  <= 1'b0;
        end else if (cmd_reject) begin
            done  <= 1'b1;
        end else if (rsp_valid && rsp_ready) begin
            got[count[2:0]] <= rsp_data;
            count           <= count + 4'h1;
            done            <= rsp_last;
        end
    end
endmodule

// ==== test/pmbus_power_telemetry_test.sv ====
// Self-checking bench of the power telemetry block.
`timescale 1ns/10ps
module pmbus_power_telemetry_test;
    import telemetry_pkg::*;

    localparam logic [6:0] ADDR = 7'h2A;
    logic              mclk, rst, ac_present, ac_shutdown, ac_cycle, pec_en;
    logic [15:0]       pin_cycle, pin_meas, iout_meas;
    logic [14:0]       pout_meas;
    logic              go, slow, cmd_valid, cmd_ready, cmd_reject;
    logic              rsp_valid, rsp_last, rsp_ready, done;
    logic [7:0]        code, cmd_code, rsp_data, coef_r;
    logic [15:0]       coef_m, coef_b;
    logic [0:7][7:0]   got;
    logic [3:0]        count;
    int                bad_count, num_checks;

    pmbus_power_telemetry #(.AVG_TICK_CYCLES(4), .UPDATE_MAX_CYCLES(200), .EOUT_CYCLES(50)) dut (
        .mclk(mclk), .rst(rst), .ac_present(ac_present), .ac_shutdown(ac_shutdown),
        .ac_cycle(ac_cycle), .pin_cycle(pin_cycle), .pin_meas(pin_meas),
        .iout_meas(iout_meas), .pout_meas(pout_meas), .dev_addr(ADDR), .pec_en(pec_en),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_ready(cmd_ready),
        .cmd_reject(cmd_reject), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .rsp_last(rsp_last), .rsp_ready(rsp_ready), .coef_m(coef_m), .coef_b(coef_b),
        .coef_r(coef_r));
    host_model host (
        .mclk(mclk), .rst(rst), .go(go), .code(code), .slow(slow), .got(got),
        .count(count), .done(done), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_ready(cmd_ready), .cmd_reject(cmd_reject), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .rsp_last(rsp_last), .rsp_ready(rsp_ready));

    always #20 mclk = ~mclk;

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        if (bad_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    function automatic logic [7:0] crc_add(input logic [7:0] c, input logic [7:0] d);
        c = c ^ d;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ({c[6:0], 1'b0} ^ 8'h07) : {c[6:0], 1'b0};
        end
        return c;
    endfunction

    function automatic logic [15:0] lin(input logic [15:0] v);
        logic [4:0] e;
        e = 5'h00;
        while (v > 16'h03FF) begin
            v = v >> 1;
            e++;
        end
        return {e, v[10:0]};
    endfunction

    task automatic host_read(input logic [7:0] c, input logic s, input logic pec,
                             input logic [3:0] n);
        logic [7:0] c8;
        @(posedge mclk);
        go   <= 1'b1;
        code <= c;
        slow <= s;
        @(posedge mclk);
        go <= 1'b0;
        repeat (60) begin
            @(posedge mclk);
            if (done === 1'b1) break;
        end
        check(count, n);
        if (pec) begin
            c8 = crc_add(crc_add(crc_add(8'h00, {ADDR, 1'b0}), c), {ADDR, 1'b1});
            for (int i = 0; i < n - 1; i++) c8 = crc_add(c8, got[i]);
            check(got[n-1], c8);
        end
    endtask

    task automatic rd_energy(input logic [7:0] c, output logic [22:0] t, output logic [23:0] n);
        host_read(c, 1'b0, 1'b1, 4'h8);
        check(got[0], 8'h06);
        check(got[2][7], 1'b0);
        t = {got[3], got[2][6:0], got[1]};
        n = {got[6], got[5], got[4]};
    endtask

    task automatic t_clear();
        ac_shutdown <= 1'b1;
        repeat (3) @(posedge mclk);
        for (int k = 0; k < 2; k++) begin
            host_read(k ? CMD_READ_EOUT : CMD_READ_EIN, 1'b1, 1'b1, 4'h8);
            check({got[1], got[2], got[3]}, 24'h000000);
            check({got[4], got[5], got[6]}, 24'h000000);
        end
        ac_shutdown <= 1'b0;
    endtask

    task automatic t_word();
        pec_en     <= 1'b1;
        ac_present <= 1'b1;
        pin_meas   <= 16'h0500;
        iout_meas  <= 16'h1F40;
        repeat (2100) @(posedge mclk);
        host_read(CMD_READ_PIN, 1'b1, 1'b1, 4'h3);
        check({got[1], got[0]}, lin(16'h0500));
        pec_en <= 1'b0;
        host_read(CMD_READ_IOUT, 1'b0, 1'b0, 4'h2);
        check({got[1], got[0]}, lin(16'h1F40));
        ac_present <= 1'b0;
        repeat (3) @(posedge mclk);
        host_read(CMD_READ_PIN, 1'b0, 1'b0, 4'h2);
        check({got[1], got[0]}, 16'h0000);
        host_read(CMD_READ_IOUT, 1'b0, 1'b0, 4'h2);
        check({got[1], got[0]}, lin(16'h1F40));
    endtask

    task automatic t_idle();
        logic [22:0] t0, t1;
        logic [23:0] n0, n1;
        rd_energy(CMD_READ_EIN, t0, n0);
        repeat (1000) @(posedge mclk);
        rd_energy(CMD_READ_EIN, t1, n1);
        check(t1, t0);
        check((n1 - n0 == 5) || (n1 - n0 == 6), 1'b1);
    endtask

    // Any four cycle powers in a row average to q.
    task automatic t_ein(input logic [15:0] q, input logic [14:0] s);
        logic [15:0] ofs [4] = '{16'h0030, 16'hFFD0, 16'h0010, 16'hFFF0};
        logic [22:0] t0, t1, e;
        logic [23:0] n0, n1, d;
        rd_energy(CMD_READ_EIN, t0, n0);
        ac_present <= 1'b1;
        for (int i = 0; i < 80; i++) begin
            @(posedge mclk);
            ac_cycle  <= 1'b1;
            pin_cycle <= q + ofs[i % 4];
            @(posedge mclk);
            ac_cycle <= 1'b0;
            repeat (8) @(posedge mclk);
        end
        rd_energy(CMD_READ_EIN, t1, n1);
        d = n1 - n0;
        check((d == 20) || (d == 21), 1'b1);
        e = 23'(d * s);
        if (t1 - t0 !== e) e = 23'((d - 1) * s);
        check(t1 - t0, e);
    endtask

    task automatic t_eout();
        logic [22:0] t;
        logic [23:0] n;
        t_clear();
        pout_meas <= 15'h7FFF;
        repeat (15000) @(posedge mclk);
        rd_energy(CMD_READ_EOUT, t, n);
        check(n > 24'd260, 1'b1);
        check(t, 23'(n * 15'h7FFF));
    endtask

    task automatic t_reject();
        host_read(8'h30, 1'b0, 1'b0, 4'h0);
        check(done, 1'b1);
        check(coef_m, 24'h000001);
        check({coef_b, coef_r}, 24'h000000);
    endtask

    initial begin
        {mclk, ac_present, ac_shutdown, ac_cycle, pec_en, go, slow} = '0;
        {pin_cycle, pin_meas, iout_meas, code} = '0;
        pout_meas  = 15'h0000;
        bad_count  = 0;
        num_checks = 0;
        rst        = 1'b1;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        t_clear();
        t_word();
        t_idle();
        t_ein(16'h1234, 15'h1234);
        t_ein(16'hF000, 15'h7FFF);
        t_eout();
        t_reject();
        wrap_up();
    end

    initial begin
        repeat (40000) @(posedge mclk);
        bad_count++;
        wrap_up();
    end
endmodule
